/* File: lcrs_pkg.sv */
package lcrs_pkg;

    // Clock
    localparam int CLK_PERIOD_NS       = 10;

    // Shift clocks: least period, split into two equal halves
    localparam int SHIFT_PERIOD_MIN_NS = 25;
    localparam int SHIFT_PERIOD_MIN_CYC =
        (SHIFT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIX_HALF_CYC        = (SHIFT_PERIOD_MIN_CYC + 1) / 2;
    localparam int PIX_CYC             = 2 * PIX_HALF_CYC;

    // Reset gate least high time
    localparam int RG_HIGH_MIN_NS      = 5;
    localparam int RG_HIGH_CYC_RAW     =
        (RG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RG_HIGH_CYC = (RG_HIGH_CYC_RAW < 1) ? 1 : RG_HIGH_CYC_RAW;

    // Transfer sequence
    localparam int TG_PRE_MIN_NS       = 0;
    localparam int TG_PRE_CYC_RAW      =
        (TG_PRE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TG_PRE_CYC  = (TG_PRE_CYC_RAW < 1) ? 1 : TG_PRE_CYC_RAW;
    localparam int PG_HIGH_MIN_NS      = 100;
    localparam int PG_HIGH_CYC         =
        (PG_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PG_TO_TG_MIN_NS     = 5;
    localparam int PG_TO_TG_CYC_RAW    =
        (PG_TO_TG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PG_TO_TG_CYC =
        (PG_TO_TG_CYC_RAW < 1) ? 1 : PG_TO_TG_CYC_RAW;

    // Cycles after the last dump before its sample has crossed the sync stage
    localparam int SYNC_DEPTH          = 2;

    // Widths
    localparam int ADC_W  = 12;
    localparam int PIX_W  = 11;
    localparam int PH_W   = 2;
    localparam int CNT_W  = 8;
    localparam int GAP_W  = 16;

    // Array variants and their last element index
    localparam logic [1:0]       VAR_512   = 2'h0;
    localparam logic [1:0]       VAR_1024  = 2'h1;
    localparam logic [1:0]       VAR_2048  = 2'h2;
    localparam logic [PIX_W-1:0] LAST_512  = 11'h1FF;
    localparam logic [PIX_W-1:0] LAST_1024 = 11'h3FF;
    localparam logic [PIX_W-1:0] LAST_2048 = 11'h7FF;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_SETUP = 8'h02,
        ST_TG    = 8'h04,
        ST_PG    = 8'h08,
        ST_PGLO  = 8'h10,
        ST_READ  = 8'h20,
        ST_TAIL  = 8'h40,
        ST_GAP   = 8'h80
    } lcrs_state_t;

    typedef struct packed {
        logic shift_phase_one;
        logic shift_phase_two;
        logic sense_node_reset_gate;
        logic overflow_drain_gate;
        logic diode_to_register_gate;
        logic storage_push_gate;
    } lcrs_pins_t;

    typedef struct packed {
        logic             last;
        logic [PIX_W-1:0] index;
        logic [ADC_W-1:0] data;
    } lcrs_word_t;

    localparam int WORD_W = $bits(lcrs_word_t);

endpackage

/* File: lcrs_buffer.sv */
`timescale 1ns/1ns
module lcrs_buffer #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } lcrs_buf_t;

    lcrs_buf_t s_q;
    lcrs_buf_t s_d;
    logic      do_wr;
    logic      do_rd;

    assign in_ready  = (s_q.cnt != CW'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = s_q.mem[s_q.rd];

    always_comb begin
        s_d   = s_q;
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        if (do_wr) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = (s_q.wr == PW'(DEPTH - 1)) ? '0 : s_q.wr + PW'(1);
        end
        if (do_rd) begin
            s_d.rd = (s_q.rd == PW'(DEPTH - 1)) ? '0 : s_q.rd + PW'(1);
        end
        if (do_wr && !do_rd) begin
            s_d.cnt = s_q.cnt + CW'(1);
        end else if (do_rd && !do_wr) begin
            s_d.cnt = s_q.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* File: lcrs_sequencer.sv */
`timescale 1ns/1ns
module lcrs_sequencer
    import lcrs_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             run,
    input  wire logic [1:0]       cfg_variant,
    input  wire logic [GAP_W-1:0] cfg_gap,
    input  wire logic [GAP_W-1:0] cfg_exposure,
    input  wire logic             cfg_expo_en,
    input  wire logic [ADC_W-1:0] adc_data,
    output lcrs_pins_t            pins,
    output logic                  busy,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output lcrs_word_t            out_word
);

    typedef struct packed {
        lcrs_state_t      state;
        logic [PH_W-1:0]  ph;
        logic [PIX_W-1:0] pix;
        logic [CNT_W-1:0] cnt;
        logic [GAP_W-1:0] gap;
        logic [PIX_W-1:0] last_pix;
        logic [GAP_W-1:0] gap_len;
        logic [GAP_W-1:0] exp_len;
        logic             ab_en;
        logic [ADC_W-1:0] adc_s1;
        logic [ADC_W-1:0] adc_s2;
        lcrs_pins_t       pins;
    } lcrs_seq_t;

    lcrs_seq_t  s_q;
    lcrs_seq_t  s_d;
    logic       push;
    logic       buf_ready;
    lcrs_word_t push_word;
    logic       in_read;
    logic       h1_low;

    lcrs_buffer #(
        .WIDTH (WORD_W),
        .DEPTH (2)
    ) u_buf (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .in_data   (push_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );

    assign pins = s_q.pins;
    assign busy = (s_q.state != ST_IDLE);

    always_comb begin
        s_d       = s_q;
        push      = 1'b0;
        push_word = '0;
        in_read   = 1'b0;
        h1_low    = 1'b0;
        s_d.adc_s1 = adc_data;
        s_d.adc_s2 = s_q.adc_s1;
        push_word.data = s_q.adc_s2;

        case (s_q.state)
            ST_IDLE, ST_GAP: begin
                if (s_q.state == ST_GAP && s_q.gap != '0) begin
                    s_d.gap = s_q.gap - GAP_W'(1);
                end else if (run) begin
                    // Settings take effect only at a line boundary
                    case (cfg_variant)
                        VAR_512:  s_d.last_pix = LAST_512;
                        VAR_1024: s_d.last_pix = LAST_1024;
                        default:  s_d.last_pix = LAST_2048;
                    endcase
                    s_d.gap_len = cfg_gap;
                    s_d.exp_len = cfg_exposure;
                    s_d.ab_en   = cfg_expo_en && (cfg_exposure < cfg_gap);
                    s_d.cnt     = CNT_W'(TG_PRE_CYC - 1);
                    s_d.state   = ST_SETUP;
                end else begin
                    s_d.state = ST_IDLE;
                end
            end
            ST_SETUP: begin
                // Shift clocks already parked, phase one high
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else begin
                    s_d.state = ST_TG;
                end
            end
            ST_TG: begin
                // Clocks stay parked through the whole transfer
                s_d.cnt   = CNT_W'(PG_HIGH_CYC - 1);
                s_d.state = ST_PG;
            end
            ST_PG: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else begin
                    s_d.cnt   = CNT_W'(PG_TO_TG_CYC - 1);
                    s_d.state = ST_PGLO;
                end
            end
            ST_PGLO: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else begin
                    // Clocks restart only as the transfer gate falls
                    s_d.ph    = '0;
                    s_d.pix   = '0;
                    s_d.state = ST_READ;
                end
            end
            ST_READ: begin
                // Previous pixel's video has passed the sync stage by now
                if (s_q.ph == PH_W'(1) && s_q.pix != '0) begin
                    push            = 1'b1;
                    push_word.index = s_q.pix - PIX_W'(1);
                end
                // Stall parks phase one high so no charge is dumped
                if (!(push && !buf_ready)) begin
                    if (s_q.ph == PH_W'(PIX_CYC - 1)) begin
                        s_d.ph = '0;
                        if (s_q.pix == s_q.last_pix) begin
                            s_d.cnt   = CNT_W'(SYNC_DEPTH - 1);
                            s_d.state = ST_TAIL;
                        end else begin
                            s_d.pix = s_q.pix + PIX_W'(1);
                        end
                    end else begin
                        s_d.ph = s_q.ph + PH_W'(1);
                    end
                end
            end
            ST_TAIL: begin
                // Last video needs SYNC_DEPTH cycles to cross the sync stage
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - CNT_W'(1);
                end else begin
                    push            = 1'b1;
                    push_word.index = s_q.pix;
                    push_word.last  = 1'b1;
                    if (buf_ready) begin
                        s_d.gap   = s_q.gap_len;
                        s_d.state = ST_GAP;
                    end
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase

        // A stalled sample must not slide on: the node was reset since
        if (push && !buf_ready) begin
            s_d.adc_s2 = s_q.adc_s2;
        end

        // Pin levels follow the next state so the pins come from flops
        in_read = (s_d.state == ST_READ);
        h1_low  = in_read && (s_d.ph >= PH_W'(PIX_HALF_CYC));
        s_d.pins.shift_phase_one = !h1_low;
        s_d.pins.shift_phase_two = h1_low;
        // High outside readout keeps the node cleared; inside, high only
        // in phase 0, so it is low a whole phase before phase one falls
        // and every dump lands on a freshly reset node
        s_d.pins.sense_node_reset_gate =
            !in_read ||
            (s_d.ph < PH_W'(RG_HIGH_CYC));
        s_d.pins.diode_to_register_gate =
            (s_d.state == ST_TG) || (s_d.state == ST_PG) ||
            (s_d.state == ST_PGLO);
        s_d.pins.storage_push_gate = (s_d.state == ST_PG);
        // Drain until the exposure window opens near line end; held low
        // from the window through the transfer so charge is collected
        s_d.pins.overflow_drain_gate = s_d.ab_en &&
            (in_read || (s_d.state == ST_TAIL) ||
             ((s_d.state == ST_GAP) && (s_d.gap > s_d.exp_len)));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
            // Parked: phase one high, node held at reference, gates low
            s_q.pins.shift_phase_one        <= 1'b1;
            s_q.pins.shift_phase_two        <= 1'b0;
            s_q.pins.sense_node_reset_gate  <= 1'b1;
            s_q.pins.overflow_drain_gate    <= 1'b0;
            s_q.pins.diode_to_register_gate <= 1'b0;
            s_q.pins.storage_push_gate      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

/* File: lcrs_sequencer_assertions.sv */
`timescale 1ns/1ns
module lcrs_checker
    import lcrs_pkg::*;
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire lcrs_pins_t pins,
    input wire logic       out_valid,
    input wire logic       out_ready,
    input wire lcrs_word_t out_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic h1 = pins.shift_phase_one;
    wire logic h2 = pins.shift_phase_two;
    wire logic rg = pins.sense_node_reset_gate;
    wire logic ab = pins.overflow_drain_gate;
    wire logic tg = pins.diode_to_register_gate;
    wire logic pg = pins.storage_push_gate;

    property p_rg_low_at_fall; $fell(h1) |-> !$past(rg); endproperty
    a_rg_low_at_fall: assert property (p_rg_low_at_fall)
        else $error("reset gate not low before phase one fall");
    property p_period; $fell(h1) |=> (!$fell(h1))[*2]; endproperty
    a_period: assert property (p_period)
        else $error("shift clock period too short");
    property p_compl; h2 == !h1; endproperty
    a_compl: assert property (p_compl)
        else $error("shift phases not complementary");
    property p_stop; $rose(tg) |-> h1 && !h2 && $past(h1) && !ab; endproperty
    a_stop: assert property (p_stop)
        else $error("transfer raised with clocks running or drain high");
    property p_pg_width; $rose(pg) |-> $past(tg) ##1 pg[*8] ##1 pg; endproperty
    a_pg_width: assert property (p_pg_width)
        else $error("photo gate pulse short or before transfer");
    property p_pg_first; $fell(tg) |-> !pg && !$past(pg); endproperty
    a_pg_first: assert property (p_pg_first)
        else $error("transfer gate fell before photo gate");
    property p_still; tg |-> h1 && rg; endproperty
    a_still: assert property (p_still)
        else $error("shift clocks moved during transfer");
    property p_rg_pulse; $rose(h1) |-> rg; endproperty
    a_rg_pulse: assert property (p_rg_pulse)
        else $error("pixel started without reset pulse");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_word);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stream word changed while stalled");
    c_xfer: cover property ($rose(pg));
    c_last: cover property (out_valid && out_ready && out_word.last);
    c_stall: cover property ((out_valid && !out_ready) [*4]);
    c_expo: cover property ($fell(ab));
endmodule
bind lcrs_sequencer lcrs_checker u_chk (.clk(clk), .nrst(nrst), .pins(pins),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));

/* File: lcrs_imager_model.sv */
`timescale 1ns/1ns
module lcrs_imager_model
    import lcrs_pkg::*;
(
    input  wire lcrs_pins_t  pins,
    output logic [ADC_W-1:0] adc_data
);
    logic [PIX_W-1:0] idx;
    logic             drained_q;
    logic             line_drained;
    initial begin
        adc_data = 12'h000;
        idx = 11'h000;
        drained_q = 1'b0;
        line_drained = 1'b0;
    end
    // Drain seen at shift edges, never on the transfer edge it races with
    always @(negedge pins.shift_phase_one) begin
        if (pins.overflow_drain_gate) drained_q = 1'b1;
    end
    // Flag rides with the charge, so it shows one line later
    always @(negedge pins.diode_to_register_gate) begin
        line_drained = drained_q;
        drained_q = 1'b0;
        idx = 11'h000;
    end
    // Video is {drained, element index}; clipped if reset still high
    always @(negedge pins.shift_phase_one) begin
        adc_data = pins.sense_node_reset_gate ? 12'hFFF : {line_drained, idx};
        idx = idx + 11'h001;
    end
    always @(posedge pins.sense_node_reset_gate) adc_data = ~adc_data;
endmodule

/* File: lcrs_sequencer_tb.sv */
`timescale 1ns/1ns
module lcrs_sequencer_tb
    import lcrs_pkg::*;
;
    logic             clk, nrst, run, cfg_expo_en, out_ready, out_valid, busy;
    logic [1:0]       cfg_variant;
    logic [GAP_W-1:0] cfg_gap, cfg_exposure;
    logic [ADC_W-1:0] adc_data;
    lcrs_pins_t       pins;
    lcrs_word_t       out_word;
    int               n_fail, samples_checked, cyc;

    lcrs_sequencer dut (.clk(clk), .nrst(nrst), .run(run),
        .cfg_variant(cfg_variant), .cfg_gap(cfg_gap),
        .cfg_exposure(cfg_exposure), .cfg_expo_en(cfg_expo_en),
        .adc_data(adc_data), .pins(pins), .busy(busy),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
    lcrs_imager_model model (.pins(pins), .adc_data(adc_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop;
        end
    end

    task check_idle;
        check(WORD_W'(pins), WORD_W'(6'h28));
        check(WORD_W'({busy, out_valid}), WORD_W'(2'h0));
    endtask

    // One line; a stalling consumer drops ready 16 of every 32 cycles
    task run_line(input logic [1:0] v, input int n, input logic dr,
                  input bit stall);
        int i, k;
        i = 0;
        k = 0;
        cfg_variant <= v;
        run <= 1'b1;
        @(posedge clk);
        while (busy !== 1'b1) @(posedge clk);
        run <= 1'b0;
        while (i < n) begin
            @(posedge clk);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                check(out_word, {i == n - 1, i[10:0], dr, i[10:0]});
                i++;
            end
            out_ready <= !stall || k[4];
            k++;
        end
        out_ready <= 1'b1;
        while (busy === 1'b1) @(posedge clk);
        @(posedge clk);
        check_idle;
        $display("line done: variant %0d words %0d", v, n);
    endtask

    task t_variants;
        // Codes 2 and 3 both select the longest array
        for (int v = 0; v < 4; v++) begin
            run_line(2'(v), 512 << ((v > 2) ? 2 : v), 1'b0, 1'b0);
        end
        $display("variants test done");
    endtask

    task t_stall;
        run_line(2'h0, 512, 1'b0, 1'b1);
        $display("stall test done");
    endtask

    task t_abort;
        run <= 1'b1;
        repeat (300) @(posedge clk);
        nrst <= 1'b0;
        run <= 1'b0;
        repeat (2) @(posedge clk);
        check_idle;
        nrst <= 1'b1;
        @(posedge clk);
        check_idle;
        run_line(2'h0, 512, 1'b0, 1'b0);
        $display("abort test done");
    endtask

    task t_expo;
        cfg_expo_en <= 1'b1;
        cfg_gap <= 16'h0040;
        cfg_exposure <= 16'h0010;
        run_line(2'h0, 512, 1'b0, 1'b0);
        run_line(2'h0, 512, 1'b1, 1'b0);
        cfg_expo_en <= 1'b0;
        run_line(2'h0, 512, 1'b1, 1'b0);
        run_line(2'h0, 512, 1'b0, 1'b0);
        $display("exposure test done");
    endtask

    initial begin
        n_fail = 0;
        samples_checked = 0;
        cyc = 0;
        nrst = 1'b0;
        run = 1'b0;
        cfg_variant = 2'h0;
        cfg_gap = 16'h0008;
        cfg_exposure = 16'h0000;
        cfg_expo_en = 1'b0;
        out_ready = 1'b1;
        repeat (5) @(posedge clk);
        check_idle;
        nrst <= 1'b1;
        @(posedge clk);
        check_idle;
        t_variants;
        t_stall;
        t_abort;
        t_expo;
        report_and_stop;
    end
endmodule
